// [logic/lsr_pkg.sv]
// shared constants and types for the light sensor register block
// assumes a host that addresses the target word by word over the two-wire bus
package lsr_pkg;
    // command codes
    localparam logic [7:0] CMD_CONFIG = 8'h00;
    localparam logic [7:0] CMD_UPPER = 8'h01;
    localparam logic [7:0] CMD_LOWER = 8'h02;
    localparam logic [7:0] CMD_PSAVE = 8'h03;
    localparam logic [7:0] CMD_LIGHT = 8'h04;
    localparam logic [7:0] CMD_BROAD = 8'h05;
    localparam logic [7:0] CMD_FLAGS = 8'h06;
    // bus target address
    localparam logic [6:0] TARGET_ADDR = 7'h10;
    // light_config fields
    localparam logic [15:0] CONFIG_RESET = 16'h0001;
    localparam int GAIN_LSB = 11;
    localparam int PERIOD_LSB = 6;
    localparam int PERSIST_LSB = 4;
    localparam int IRQ_EN_BIT = 1;
    localparam int SHUTDOWN_BIT = 0;
    // power_save_ctrl fields
    localparam int PS_MODE_LSB = 1;
    localparam int PS_EN_BIT = 0;
    localparam logic [15:0] PSAVE_RESET = 16'h0000;
    // threshold_event_flags fields, limit word reset
    localparam int BELOW_FLAG_BIT = 15;
    localparam int ABOVE_FLAG_BIT = 14;
    localparam logic [15:0] LIMIT_RESET = 16'h0000;

    typedef struct packed {
        logic [7:0] code;
        logic [15:0] data;
    } lsr_wr_t;

    typedef struct packed {
        logic [15:0] light;
        logic [15:0] broad;
        logic [15:0] flags;
    } lsr_rd_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_MACK = 3'b100
    } lsr_state_t;

    typedef enum logic [1:0] {
        PH_ADDR = 2'b00,
        PH_CMD = 2'b01,
        PH_DATA = 2'b10
    } lsr_phase_t;
endpackage

// [logic/lsr_light_sensor.sv]
// light sensor register block: bus target on the link clock, registers on clk
// assumes the front end hands over results in the clk domain with a valid pulse
//
// How it works
// - config word at code 00, reserved written zero
// - config resets to one: starts shut down
// - config bits 12:11 select gain
// - config bits 9:6 select integration period
// - config bits 5:4 persistence 1,2,4,8
// - config bit 1 enables threshold events
// - config bit 0 set shuts sensing down
// - upper limit word at code 01
// - lower limit word at code 02
// - ambient result readable at code 04
// - broadband result readable at code 05
// - event flags word readable at code 06
// - no interrupt pin; host polls flags
// - answer only target address 0x10
// - bit 15 below flag, bit 14 above
// - shutdown keeps last result readable
// - power save bits 2:1 mode, bit 0 enable
`timescale 1ns/1ps
`default_nettype none
module lsr_light_sensor
    import lsr_pkg::*;
(
    // system clock and reset
    input wire logic clk,
    input wire logic rst,
    // link clock and bus pins
    input wire logic linkClk,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    // front end results
    input wire logic sampleValid,
    input wire logic [15:0] lightSample,
    input wire logic [15:0] broadSample,
    // front end controls
    output logic sensorShutdown,
    output logic [1:0] gainSelect,
    output logic [3:0] integrationPeriod,
    output logic [1:0] powerSaveMode,
    output logic powerSaveEnable
);
    // ========================================
    // link domain: bus target
    // ========================================
    logic sclA_r, sclS_r, sclD_r, sdaA_r, sdaS_r, sdaD_r;
    logic snapReqA_r, snapReqS_r;
    lsr_state_t st_r, st_nxt;
    lsr_phase_t ph_r, ph_nxt;
    logic [3:0] bitCnt_r, bitCnt_nxt;
    logic [7:0] shift_r, shift_nxt, cmd_r, cmd_nxt, lowByte_r, lowByte_nxt;
    logic [15:0] txWord_r, txWord_nxt;
    logic isRead_r, isRead_nxt, hiByte_r, hiByte_nxt, nak_r, nak_nxt;
    logic oeN_r, oeN_nxt, wrTgl_r, wrTgl_nxt, clrTgl_r, clrTgl_nxt;
    logic snapAck_r, snapAck_nxt;
    lsr_wr_t wrWord_r, wrWord_nxt;
    lsr_rd_t linkRd_r, linkRd_nxt;
    // snapshot handshake state lives on clk, declared here since the link side reads it
    logic snapReq_r, snapReq_nxt;
    lsr_rd_t snapHold_r, snapHold_nxt;
    logic sclRise, sclFall, startEv, stopEv;
    logic [15:0] selWord;

    assign sclRise = sclS_r & ~sclD_r;
    assign sclFall = ~sclS_r & sclD_r;
    assign startEv = sclS_r & sclD_r & sdaD_r & ~sdaS_r;
    assign stopEv = sclS_r & sclD_r & ~sdaD_r & sdaS_r;

    // zero for the write-only codes
    always_comb begin
        case (cmd_r)
            CMD_LIGHT: selWord = linkRd_r.light;
            CMD_BROAD: selWord = linkRd_r.broad;
            CMD_FLAGS: selWord = linkRd_r.flags;
            default: selWord = 16'h0000;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        ph_nxt = ph_r;
        bitCnt_nxt = bitCnt_r;
        shift_nxt = shift_r;
        cmd_nxt = cmd_r;
        lowByte_nxt = lowByte_r;
        txWord_nxt = txWord_r;
        isRead_nxt = isRead_r;
        hiByte_nxt = hiByte_r;
        nak_nxt = nak_r;
        oeN_nxt = oeN_r;
        wrTgl_nxt = wrTgl_r;
        clrTgl_nxt = clrTgl_r;
        wrWord_nxt = wrWord_r;
        snapAck_nxt = snapAck_r;
        linkRd_nxt = linkRd_r;
        // snapshot is stable while the request stays unanswered
        if (snapReqS_r != snapAck_r) begin
            linkRd_nxt = snapHold_r;
            snapAck_nxt = snapReqS_r;
        end
        if (startEv) begin
            st_nxt = ST_RX;
            ph_nxt = PH_ADDR;
            bitCnt_nxt = 4'h0;
            oeN_nxt = 1'b1;
        end else if (stopEv) begin
            st_nxt = ST_IDLE;
            oeN_nxt = 1'b1;
        end else begin
            case (st_r)
                ST_RX: begin
                    if (sclRise) begin
                        shift_nxt = {shift_r[6:0], sdaS_r};
                        bitCnt_nxt = bitCnt_r + 4'h1;
                    end else if (sclFall && bitCnt_r == 4'h8) begin
                        bitCnt_nxt = 4'h0;
                        st_nxt = ST_ACK;
                        oeN_nxt = 1'b0;
                        case (ph_r)
                            PH_ADDR: begin
                                isRead_nxt = shift_r[0];
                                hiByte_nxt = 1'b0;
                                if (shift_r[7:1] != TARGET_ADDR) begin
                                    st_nxt = ST_IDLE;
                                    oeN_nxt = 1'b1;
                                end
                            end
                            PH_CMD: begin
                                cmd_nxt = shift_r;
                                hiByte_nxt = 1'b0;
                            end
                            default: begin
                                hiByte_nxt = ~hiByte_r;
                                if (!hiByte_r) begin
                                    lowByte_nxt = shift_r;
                                end else begin
                                    wrWord_nxt = '{code: cmd_r, data: {shift_r, lowByte_r}};
                                    wrTgl_nxt = ~wrTgl_r;
                                end
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (sclFall) begin
                        oeN_nxt = 1'b1;
                        st_nxt = ST_RX;
                        ph_nxt = (ph_r == PH_ADDR) ? PH_CMD : PH_DATA;
                        if (ph_r == PH_ADDR && isRead_r) begin
                            // whole word latched at the low byte so halves never tear
                            st_nxt = ST_TX;
                            txWord_nxt = selWord;
                            oeN_nxt = selWord[7];
                            shift_nxt = {selWord[6:0], 1'b0};
                            bitCnt_nxt = 4'h1;
                            if (cmd_r == CMD_FLAGS) begin
                                clrTgl_nxt = ~clrTgl_r;
                            end
                        end
                    end
                end
                ST_TX: begin
                    if (sclFall) begin
                        if (bitCnt_r == 4'h8) begin
                            oeN_nxt = 1'b1;
                            bitCnt_nxt = 4'h0;
                            st_nxt = ST_MACK;
                        end else begin
                            oeN_nxt = shift_r[7];
                            shift_nxt = {shift_r[6:0], 1'b0};
                            bitCnt_nxt = bitCnt_r + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (sclRise) begin
                        nak_nxt = sdaS_r;
                    end else if (sclFall) begin
                        if (nak_r) begin
                            st_nxt = ST_IDLE;
                        end else begin
                            st_nxt = ST_TX;
                            hiByte_nxt = ~hiByte_r;
                            bitCnt_nxt = 4'h1;
                            if (hiByte_r) begin
                                txWord_nxt = selWord;
                                oeN_nxt = selWord[7];
                                shift_nxt = {selWord[6:0], 1'b0};
                            end else begin
                                oeN_nxt = txWord_r[15];
                                shift_nxt = {txWord_r[14:8], 1'b0};
                            end
                        end
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            {sclA_r, sclS_r, sclD_r, sdaA_r, sdaS_r, sdaD_r} <= 6'h3f;
            {snapReqA_r, snapReqS_r, snapAck_r} <= 3'h0;
            st_r <= ST_IDLE;
            ph_r <= PH_ADDR;
            bitCnt_r <= 4'h0;
            shift_r <= 8'h00;
            cmd_r <= 8'h00;
            lowByte_r <= 8'h00;
            txWord_r <= 16'h0000;
            {isRead_r, hiByte_r, nak_r, wrTgl_r, clrTgl_r} <= 5'h00;
            oeN_r <= 1'b1;
            sdaOut <= 1'b0;
            sdaOeN <= 1'b1;
            wrWord_r <= '0;
            linkRd_r <= '0;
        end else begin
            {sclA_r, sclS_r, sclD_r} <= {sclIn, sclA_r, sclS_r};
            {sdaA_r, sdaS_r, sdaD_r} <= {sdaIn, sdaA_r, sdaS_r};
            {snapReqA_r, snapReqS_r} <= {snapReq_r, snapReqA_r};
            st_r <= st_nxt;
            ph_r <= ph_nxt;
            bitCnt_r <= bitCnt_nxt;
            shift_r <= shift_nxt;
            cmd_r <= cmd_nxt;
            lowByte_r <= lowByte_nxt;
            txWord_r <= txWord_nxt;
            {isRead_r, hiByte_r, nak_r} <= {isRead_nxt, hiByte_nxt, nak_nxt};
            {wrTgl_r, clrTgl_r, snapAck_r} <= {wrTgl_nxt, clrTgl_nxt, snapAck_nxt};
            oeN_r <= oeN_nxt;
            sdaOut <= 1'b0;
            sdaOeN <= oeN_nxt;
            wrWord_r <= wrWord_nxt;
            linkRd_r <= linkRd_nxt;
        end
    end

    // ========================================
    // clk domain: registers and threshold events
    // ========================================
    logic wrA_r, wrS_r, wrD_r, clrA_r, clrS_r, clrD_r, ackA_r, ackS_r;
    logic [15:0] config_r, config_nxt, psave_r, psave_nxt;
    logic [15:0] upper_r, upper_nxt, lower_r, lower_nxt;
    logic [15:0] light_r, light_nxt, broad_r, broad_nxt;
    logic [3:0] hiCnt_r, hiCnt_nxt, loCnt_r, loCnt_nxt;
    logic aboveFlag_r, aboveFlag_nxt, belowFlag_r, belowFlag_nxt;
    logic wrHit, clrHit, measure;
    logic [3:0] persistN;

    assign wrHit = wrS_r ^ wrD_r;
    assign clrHit = clrS_r ^ clrD_r;
    assign measure = sampleValid & ~config_r[SHUTDOWN_BIT];
    assign persistN = 4'h1 << config_r[PERSIST_LSB +: 2];

    always_comb begin
        config_nxt = config_r;
        psave_nxt = psave_r;
        upper_nxt = upper_r;
        lower_nxt = lower_r;
        light_nxt = light_r;
        broad_nxt = broad_r;
        hiCnt_nxt = hiCnt_r;
        loCnt_nxt = loCnt_r;
        aboveFlag_nxt = aboveFlag_r;
        belowFlag_nxt = belowFlag_r;
        snapReq_nxt = snapReq_r;
        snapHold_nxt = snapHold_r;
        if (wrHit) begin
            case (wrWord_r.code)
                CMD_CONFIG: config_nxt = wrWord_r.data;
                CMD_UPPER: upper_nxt = wrWord_r.data;
                CMD_LOWER: lower_nxt = wrWord_r.data;
                CMD_PSAVE: psave_nxt = wrWord_r.data;
                default: ;
            endcase
        end
        // read of the flags word clears them; a fresh event in that cycle still lands
        if (clrHit) begin
            aboveFlag_nxt = 1'b0;
            belowFlag_nxt = 1'b0;
        end
        if (!config_r[IRQ_EN_BIT]) begin
            hiCnt_nxt = 4'h0;
            loCnt_nxt = 4'h0;
        end
        if (measure) begin
            light_nxt = lightSample;
            broad_nxt = broadSample;
            if (config_r[IRQ_EN_BIT]) begin
                hiCnt_nxt = (lightSample <= upper_r) ? 4'h0 :
                    (hiCnt_r == 4'h8) ? hiCnt_r : hiCnt_r + 4'h1;
                loCnt_nxt = (lightSample >= lower_r) ? 4'h0 :
                    (loCnt_r == 4'h8) ? loCnt_r : loCnt_r + 4'h1;
                if (hiCnt_nxt >= persistN) begin
                    aboveFlag_nxt = 1'b1;
                end
                if (loCnt_nxt >= persistN) begin
                    belowFlag_nxt = 1'b1;
                end
            end
        end
        if (ackS_r == snapReq_r) begin
            snapHold_nxt.light = light_r;
            snapHold_nxt.broad = broad_r;
            snapHold_nxt.flags = 16'h0000;
            snapHold_nxt.flags[BELOW_FLAG_BIT] = belowFlag_r;
            snapHold_nxt.flags[ABOVE_FLAG_BIT] = aboveFlag_r;
            snapReq_nxt = ~snapReq_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {wrA_r, wrS_r, wrD_r, clrA_r, clrS_r, clrD_r, ackA_r, ackS_r} <= 8'h00;
            config_r <= CONFIG_RESET;
            psave_r <= PSAVE_RESET;
            upper_r <= LIMIT_RESET;
            lower_r <= LIMIT_RESET;
            light_r <= 16'h0000;
            broad_r <= 16'h0000;
            hiCnt_r <= 4'h0;
            loCnt_r <= 4'h0;
            {aboveFlag_r, belowFlag_r, snapReq_r} <= 3'h0;
            snapHold_r <= '0;
        end else begin
            {wrA_r, wrS_r, wrD_r} <= {wrTgl_r, wrA_r, wrS_r};
            {clrA_r, clrS_r, clrD_r} <= {clrTgl_r, clrA_r, clrS_r};
            {ackA_r, ackS_r} <= {snapAck_r, ackA_r};
            config_r <= config_nxt;
            psave_r <= psave_nxt;
            upper_r <= upper_nxt;
            lower_r <= lower_nxt;
            light_r <= light_nxt;
            broad_r <= broad_nxt;
            hiCnt_r <= hiCnt_nxt;
            loCnt_r <= loCnt_nxt;
            {aboveFlag_r, belowFlag_r, snapReq_r} <= {aboveFlag_nxt, belowFlag_nxt, snapReq_nxt};
            snapHold_r <= snapHold_nxt;
        end
    end

    assign sensorShutdown = config_r[SHUTDOWN_BIT];
    assign gainSelect = config_r[GAIN_LSB +: 2];
    assign integrationPeriod = config_r[PERIOD_LSB +: 4];
    assign powerSaveMode = psave_r[PS_MODE_LSB +: 2];
    assign powerSaveEnable = psave_r[PS_EN_BIT];

    // ========================================
    // checks
    // ========================================
    AST_RESET_SHUT: assert property (@(posedge clk) $fell(rst) |-> config_r == CONFIG_RESET)
        else $error("config not one after reset");
    AST_CFG_WRITE: assert property (@(posedge clk) disable iff (rst)
        wrHit && wrWord_r.code == CMD_CONFIG |=> config_r == $past(wrWord_r.data))
        else $error("config write lost");
    AST_UPPER_WRITE: assert property (@(posedge clk) disable iff (rst)
        wrHit && wrWord_r.code == CMD_UPPER |=> upper_r == $past(wrWord_r.data))
        else $error("upper limit write lost");
    AST_LOWER_WRITE: assert property (@(posedge clk) disable iff (rst)
        wrHit && wrWord_r.code == CMD_LOWER |=> lower_r == $past(wrWord_r.data))
        else $error("lower limit write lost");
    AST_HOLD_IN_SD: assert property (@(posedge clk) disable iff (rst)
        config_r[SHUTDOWN_BIT] |=> $stable(light_r) && $stable(broad_r))
        else $error("result changed in shutdown");
    AST_RESULT_TAKE: assert property (@(posedge clk) disable iff (rst)
        measure |=> light_r == $past(lightSample) && broad_r == $past(broadSample))
        else $error("result not taken");
    AST_FLAG_NEEDS_EN: assert property (@(posedge clk) disable iff (rst)
        $rose(aboveFlag_r) || $rose(belowFlag_r) |-> $past(config_r[IRQ_EN_BIT]))
        else $error("flag set while disabled");
    AST_PERSIST: assert property (@(posedge clk) disable iff (rst)
        $rose(aboveFlag_r) |-> hiCnt_r >= $past(persistN) && hiCnt_r != 4'h0)
        else $error("flag before persistence count");
    AST_SET_WINS: assert property (@(posedge clk) disable iff (rst)
        clrHit && measure && config_r[IRQ_EN_BIT] && hiCnt_nxt >= persistN |=> aboveFlag_r)
        else $error("event lost to clear");
    AST_ADDR_MISS: assert property (@(posedge linkClk) disable iff (rst)
        st_r == ST_RX && ph_r == PH_ADDR && sclFall && bitCnt_r == 4'h8 && !startEv
        && !stopEv && shift_r[7:1] != TARGET_ADDR |=> sdaOeN ##1 st_r == ST_IDLE)
        else $error("foreign address answered");
    AST_ADDR_HIT: assert property (@(posedge linkClk) disable iff (rst)
        st_r == ST_RX && ph_r == PH_ADDR && sclFall && bitCnt_r == 4'h8 && !startEv
        && !stopEv && shift_r[7:1] == TARGET_ADDR |=> !sdaOeN && st_r == ST_ACK)
        else $error("own address not acknowledged");
    CVR_CFG: cover property (@(posedge clk) disable iff (rst)
        wrHit && wrWord_r.code == CMD_CONFIG);
    CVR_FLAG: cover property (@(posedge clk) disable iff (rst) $rose(aboveFlag_r));
    CVR_CLEAR: cover property (@(posedge clk) disable iff (rst) clrHit && belowFlag_r);
    CVR_READ: cover property (@(posedge linkClk) disable iff (rst)
        st_r == ST_MACK && sclFall && nak_r);
endmodule // lsr_light_sensor
`default_nettype wire

// [dv/lsr_i2c_host.sv]
// two-wire host model: drives the bus clock and pulls the data wire low
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module lsr_i2c_host
    import lsr_pkg::*;
(
    // bus pins
    output logic scl,
    output logic sdaLow,
    input wire logic sda
);
    // quarter bit time; keeps both clock phases above the target minimum
    localparam int Q = 70;
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    // ==========================================
    // bus primitives
    // serves as first and repeated start alike
    task automatic start();
        #Q sdaLow = 1'b0;
        #Q scl = 1'b1;
        #Q sdaLow = 1'b1;
        #Q scl = 1'b0;
    endtask
    // clock stands still high after this, until the next frame
    task automatic stop();
        #Q sdaLow = 1'b1;
        #Q scl = 1'b1;
        #Q sdaLow = 1'b0;
        #Q;
    endtask
    task automatic bitIo(input logic b, output logic s);
        #Q sdaLow = ~b;
        #Q scl = 1'b1;
        #Q s = sda;
        #Q scl = 1'b0;
    endtask
    task automatic byteIo(input logic [7:0] tx, input logic ackBit, output logic [7:0] rx,
                          inout logic [15:0] acks);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bitIo(tx[i], rx[i]);
        end
        bitIo(ackBit, a);
        acks = acks + {15'h0000, ackBit & ~a};
    endtask
    // ==========================================
    // word transfers
    task automatic wrWord(input logic [6:0] addr, input logic [7:0] code,
                          input logic [15:0] data, output logic [15:0] acks);
        logic [7:0] rx;
        acks = 16'h0000;
        start();
        byteIo({addr, 1'b0}, 1'b1, rx, acks);
        byteIo(code, 1'b1, rx, acks);
        byteIo(data[7:0], 1'b1, rx, acks);
        byteIo(data[15:8], 1'b1, rx, acks);
        stop();
    endtask
    task automatic rdWord(input logic [7:0] code, output logic [15:0] data,
                          output logic [15:0] acks);
        logic [7:0] rx;
        acks = 16'h0000;
        start();
        byteIo({TARGET_ADDR, 1'b0}, 1'b1, rx, acks);
        byteIo(code, 1'b1, rx, acks);
        start();
        byteIo({TARGET_ADDR, 1'b1}, 1'b1, rx, acks);
        byteIo(8'hFF, 1'b0, data[7:0], acks);
        byteIo(8'hFF, 1'b1, data[15:8], acks);
        stop();
    endtask
endmodule // lsr_i2c_host
`default_nettype wire

// [dv/tb_light_sensor_register_map.sv]
// self-checking bench for the light sensor register block
// assumes the host model in lsr_i2c_host and an open-drain data wire
`timescale 1ns/1ps
`default_nettype none
module tb_light_sensor_register_map;
    import lsr_pkg::*;
    logic clk, rst, linkClk, sampleValid, sdaOut, sdaOeN, sensorShutdown, powerSaveEnable;
    logic scl, hostLow, sdaWire;
    logic [15:0] lightSample, broadSample, rd, acks;
    logic [1:0] gainSelect, powerSaveMode;
    logic [3:0] integrationPeriod;
    logic [3:0] periods [6] = '{4'hC, 4'h8, 4'h0, 4'h1, 4'h2, 4'h3};
    int fail_count = 0;
    int checks = 0;
    // either side pulling low wins, pull-up otherwise
    assign sdaWire = ~hostLow & (sdaOeN | sdaOut);
    lsr_light_sensor u_lsr_light_sensor (
        .clk(clk), .rst(rst), .linkClk(linkClk), .sclIn(scl), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaOeN(sdaOeN), .sampleValid(sampleValid),
        .lightSample(lightSample), .broadSample(broadSample),
        .sensorShutdown(sensorShutdown), .gainSelect(gainSelect),
        .integrationPeriod(integrationPeriod), .powerSaveMode(powerSaveMode),
        .powerSaveEnable(powerSaveEnable)
    );
    lsr_i2c_host u_lsr_i2c_host (.scl(scl), .sdaLow(hostLow), .sda(sdaWire));
    // ==========================================
    // clocks; link clock offset so the two never line up
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        linkClk = 1'b0;
        #3.3;
        forever #7.5 linkClk = ~linkClk;
    end
    // ==========================================
    // helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %0t %s: got %h want %h", $time, msg, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic sample(input logic [15:0] l, input logic [15:0] b);
        @(negedge clk);
        lightSample = l;
        broadSample = b;
        sampleValid = 1'b1;
        @(negedge clk);
        sampleValid = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        u_lsr_i2c_host.wrWord(TARGET_ADDR, code, data, acks);
        check(acks, 16'h0004, "write acks");
    endtask
    task automatic rdExp(input logic [7:0] code, input logic [15:0] exp, input string msg);
        u_lsr_i2c_host.rdWord(code, rd, acks);
        check(rd, exp, msg);
    endtask
    function automatic logic [15:0] ctl();
        return {6'h00, powerSaveMode, powerSaveEnable, gainSelect, integrationPeriod,
                sensorShutdown};
    endfunction
    // ==========================================
    // tests
    initial begin
        rst = 1'b1;
        sampleValid = 1'b0;
        lightSample = 16'h0000;
        broadSample = 16'h0000;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (20) @(negedge clk);
        check(ctl(), 16'h0001, "reset controls");
        rdExp(CMD_CONFIG, 16'h0000, "config write only");
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            // reserved bits always written zero
            wr(CMD_CONFIG, {3'b000, 2'(i), 1'b0, periods[i], 2'(i), 2'b00, 1'b1, 1'(i)});
            check(ctl(), {9'h000, 2'(i), periods[i], 1'(i)}, "config fields");
        end
        $display("test config done");
        wr(CMD_PSAVE, 16'h0005);
        check(ctl(), {6'h00, 3'b101, 2'd1, 4'h3, 1'b1}, "power save");
        u_lsr_i2c_host.wrWord(7'h11, CMD_CONFIG, 16'h0000, acks);
        check(acks, 16'h0000, "foreign address acked");
        check(ctl(), {6'h00, 3'b101, 2'd1, 4'h3, 1'b1}, "foreign write taken");
        $display("test address done");
        wr(CMD_UPPER, 16'h1000);
        wr(CMD_LOWER, 16'h0100);
        wr(CMD_CONFIG, 16'h0012);
        sample(16'h2000, 16'h3C5A);
        rdExp(CMD_FLAGS, 16'h0000, "one crossing of two");
        rdExp(CMD_LIGHT, 16'h2000, "ambient result");
        rdExp(CMD_BROAD, 16'h3C5A, "broadband result");
        sample(16'h2000, 16'h3C5A);
        rdExp(CMD_FLAGS, 16'h4000, "above flag");
        rdExp(CMD_FLAGS, 16'h0000, "flags cleared by read");
        sample(16'h0050, 16'h0001);
        sample(16'h0050, 16'h0001);
        rdExp(CMD_FLAGS, 16'h8000, "below flag");
        $display("test thresholds done");
        wr(CMD_CONFIG, 16'h0011);
        sample(16'h0777, 16'h0888);
        rdExp(CMD_LIGHT, 16'h0050, "result kept in shutdown");
        wr(CMD_CONFIG, 16'h0010);
        sample(16'h3000, 16'h0888);
        sample(16'h3000, 16'h0888);
        rdExp(CMD_LIGHT, 16'h3000, "result refreshed on wake");
        rdExp(CMD_FLAGS, 16'h0000, "events disabled");
        $display("test shutdown done");
        // results arrive every cycle so a flag clear lands on a measuring cycle
        wr(CMD_CONFIG, 16'h0002);
        @(negedge clk);
        lightSample = 16'h2000;
        sampleValid = 1'b1;
        rdExp(CMD_FLAGS, 16'h4000, "flag on steady crossing");
        rdExp(CMD_FLAGS, 16'h4000, "set wins over clear");
        @(negedge clk);
        sampleValid = 1'b0;
        $display("test set wins done");
        summarize();
    end
    // whole run is near 310 us of bus traffic
    initial begin
        #350000;
        fail_count++;
        $display("FAIL %0t watchdog expired", $time);
        summarize();
    end
endmodule // tb_light_sensor_register_map
`default_nettype wire
